// [rtl/ftpc_checker.sv]
/*
 Far-transfer privilege checker: direct transfers and call gates.
 Assumes requests come from core logic on i_clk, one at a time, with the
 descriptor images already fetched; answers one cycle after a request.
*/
module ftpc_checker
    import ftpc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_req,
    input wire logic i_far,
    input wire ftpc_pkg::ftpc_xfer_type i_xfer,
    input wire logic i_via_gate,
    input wire ftpc_pkg::ftpc_tbl_type i_gate_tbl,
    input wire logic [127:0] i_gate_desc,
    input wire logic i_ext_mode,
    input wire logic [1:0] i_current_priv_level,
    input wire logic [15:0] i_sel,
    input wire logic i_cs_conforming,
    input wire logic [1:0] i_cs_descriptor_priv_level,
    input wire logic i_cs_long,
    input wire logic i_cs_default_size,
    input wire logic i_upper_half_access,
    output logic o_done,
    output logic [1:0] o_outcome,
    output logic [15:0] o_fault_sel,
    output logic [15:0] o_cs_sel,
    output logic [63:0] o_entry_offset,
    output logic [1:0] o_new_priv_level,
    output logic o_stack_switch,
    output logic [3:0] o_push_bytes,
    output logic [4:0] o_copy_count,
    output logic o_copy_dwords
);
    import ftpc_pkg::*;

    typedef struct packed {
        logic done;
        logic [1:0] outcome;
        logic [15:0] fault_sel;
        logic [15:0] cs_sel;
        logic [63:0] entry_offset;
        logic [1:0] new_priv_level;
        logic stack_switch;
        logic [3:0] push_bytes;
        logic [4:0] copy_count;
        logic copy_dwords;
    } ftpc_state_type;

    ftpc_state_type st;
    ftpc_state_type next_st;
    ftpc_gate_if gate ();

    ftpc_gate_decode u_decode (
        .i_desc(i_gate_desc),
        .i_ext_mode(i_ext_mode),
        .gate(gate.decoder)
    );

    logic [1:0] selector_request_level;
    logic [1:0] gate_request_level;
    logic [15:0] dest_sel;
    logic priv_ok;
    logic lvl_fault;

    assign gate_request_level = i_sel[`FTPC_SEL_REQ_LSB +: 2];

    // One check per request; result held in the state until the next request
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        dest_sel = i_via_gate ? gate.target_sel : i_sel;
        selector_request_level = dest_sel[`FTPC_SEL_REQ_LSB +: 2];
        priv_ok = 1'b1;
        lvl_fault = 1'b0;
        if (i_req) begin
            next_st.done = 1'b1;
            next_st.outcome = `FTPC_OUT_PASS;
            next_st.fault_sel = 16'h0000;
            next_st.cs_sel = i_sel;
            next_st.entry_offset = 64'h0;
            next_st.new_priv_level = i_current_priv_level;
            next_st.stack_switch = 1'b0;
            next_st.push_bytes = `FTPC_PUSH_4B;
            next_st.copy_count = 5'h00;
            next_st.copy_dwords = 1'b0;
            if (!i_far) begin
                // Near forms stay in the current segment: nothing to check
                next_st.outcome = `FTPC_OUT_PASS;
            end else if (!i_via_gate) begin
                // Direct far transfer; conforming flag picks the rule set
                if (i_cs_conforming) begin
                    // Request level deliberately not consulted here
                    priv_ok = i_current_priv_level >= i_cs_descriptor_priv_level;
                end else begin
                    priv_ok = (i_current_priv_level == i_cs_descriptor_priv_level)
                        && (selector_request_level <= i_current_priv_level);
                end
                if (!priv_ok) begin
                    next_st.outcome = `FTPC_OUT_PROT;
                    next_st.fault_sel = i_sel;
                end
                // Level field of the loaded selector is always the caller's level
                next_st.cs_sel = {i_sel[15:2], i_current_priv_level};
            end else begin
                // Gate path: table, presence, format, gate level, then target
                if (i_gate_tbl == ftpc_tbl_intr || gate.kind == ftpc_g_none
                    || i_upper_half_access) begin
                    next_st.outcome = `FTPC_OUT_PROT;
                    next_st.fault_sel = i_sel;
                end else if (i_ext_mode && gate.kind == ftpc_g_16) begin
                    next_st.outcome = `FTPC_OUT_PROT;
                    next_st.fault_sel = i_sel;
                end else if (!gate.present) begin
                    next_st.outcome = `FTPC_OUT_NOTP;
                    next_st.fault_sel = i_sel;
                end else if (gate.bad_format) begin
                    next_st.outcome = `FTPC_OUT_PROT;
                    next_st.fault_sel = i_sel;
                end else if (i_current_priv_level > gate.gate_level || gate_request_level > gate.gate_level) begin
                    next_st.outcome = `FTPC_OUT_PROT;
                    next_st.fault_sel = i_sel;
                end else if (gate.kind == ftpc_g_64 && !(i_cs_long && !i_cs_default_size)) begin
                    next_st.outcome = `FTPC_OUT_PROT;
                    next_st.fault_sel = gate.target_sel;
                end else begin
                    // Target segment checks; lower-level entry only by call to nonconforming
                    if (i_cs_conforming) begin
                        lvl_fault = i_cs_descriptor_priv_level > i_current_priv_level;
                    end else if (i_xfer == ftpc_xfer_call) begin
                        lvl_fault = i_cs_descriptor_priv_level > i_current_priv_level;
                    end else begin
                        lvl_fault = i_cs_descriptor_priv_level != i_current_priv_level;
                    end
                    if (lvl_fault) begin
                        next_st.outcome = `FTPC_OUT_PROT;
                        next_st.fault_sel = gate.target_sel;
                    end else begin
                        next_st.entry_offset = gate.entry_offset;
                        if (!i_cs_conforming && i_cs_descriptor_priv_level < i_current_priv_level) begin
                            next_st.new_priv_level = i_cs_descriptor_priv_level;
                            next_st.stack_switch = 1'b1;
                        end
                        next_st.cs_sel = {gate.target_sel[15:2], next_st.new_priv_level};
                    end
                end
                // Push width and copy unit follow the gate size
                case (gate.kind)
                    ftpc_g_16: begin
                        next_st.push_bytes = `FTPC_PUSH_2B;
                        next_st.copy_dwords = 1'b0;
                    end
                    ftpc_g_32: begin
                        next_st.push_bytes = `FTPC_PUSH_4B;
                        next_st.copy_dwords = 1'b1;
                    end
                    ftpc_g_64: begin
                        next_st.push_bytes = `FTPC_PUSH_8B;
                        next_st.copy_dwords = 1'b0;
                    end
                    default: begin
                        next_st.push_bytes = `FTPC_PUSH_4B;
                        next_st.copy_dwords = 1'b0;
                    end
                endcase
                // Copy only on a stack switch, never for wide gates
                if (next_st.stack_switch && gate.kind != ftpc_g_64) begin
                    next_st.copy_count = gate.param_count;
                end
            end
        end
    end

    // State register; all outputs come straight from it
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_done = st.done;
    assign o_outcome = st.outcome;
    assign o_fault_sel = st.fault_sel;
    assign o_cs_sel = st.cs_sel;
    assign o_entry_offset = st.entry_offset;
    assign o_new_priv_level = st.new_priv_level;
    assign o_stack_switch = st.stack_switch;
    assign o_push_bytes = st.push_bytes;
    assign o_copy_count = st.copy_count;
    assign o_copy_dwords = st.copy_dwords;
endmodule

// [rtl/ftpc_gate_decode.sv]
/*
 Combinational decode of a 16-byte gate image into its fields.
 Assumes the image is stable while the checker samples it.
*/
module ftpc_gate_decode
    import ftpc_pkg::*;
(
    input wire logic [127:0] i_desc,
    input wire logic i_ext_mode,
    ftpc_gate_if.decoder gate
);
    logic [3:0] gtype;
    logic sys_seg;
    logic [63:0] wide_off;

    // Type nibble and system flag select gate kind
    always_comb begin
        gtype = i_desc[`FTPC_G_TYPE_LSB +: 4];
        sys_seg = ~i_desc[`FTPC_G_S_BIT];
        wide_off = {i_desc[`FTPC_G_OFFUP_LSB +: 32], i_desc[`FTPC_G_OFFHI_LSB +: 16],
            i_desc[`FTPC_G_OFFLO_LSB +: 16]};
        gate.kind = ftpc_g_none;
        if (sys_seg && gtype == `FTPC_GATE32_TYPE) begin
            gate.kind = i_ext_mode ? ftpc_g_64 : ftpc_g_32;
        end else if (sys_seg && gtype == `FTPC_GATE16_TYPE) begin
            gate.kind = ftpc_g_16;
        end
        gate.present = i_desc[`FTPC_G_P_BIT];
        gate.gate_level = i_desc[`FTPC_G_LEVEL_LSB +: 2];
        gate.target_sel = i_desc[`FTPC_G_SEL_LSB +: 16];
        gate.entry_offset = i_ext_mode ? wide_off : {32'h0, wide_off[31:0]};
        // Wide gates carry no copy count
        gate.param_count = i_ext_mode ? 5'h0 : i_desc[`FTPC_G_CNT_LSB +: 5];
        // Upper type must be zero and offset sign-extended from bit 47
        gate.bad_format = i_ext_mode && ((i_desc[`FTPC_G_UPTYPE_LSB +: 5] != 5'h0)
            || (wide_off[63:`FTPC_CANON_MSB] != {17{wide_off[`FTPC_CANON_MSB]}}));
    end
endmodule

// [rtl/ftpc_gate_if.sv]
/*
 Carries decoded call-gate fields from the decode helper to the checker.
 Assumes both ends share one clock domain; purely combinational fields.
*/
interface ftpc_gate_if;
    import ftpc_pkg::*;
    ftpc_gate_kind_type kind;
    logic present;
    logic [1:0] gate_level;
    logic [15:0] target_sel;
    logic [63:0] entry_offset;
    logic [4:0] param_count;
    logic bad_format;
    modport decoder (output kind, present, gate_level, target_sel, entry_offset, param_count, bad_format);
    modport checker_end (input kind, present, gate_level, target_sel, entry_offset, param_count, bad_format);
endinterface

// [rtl/ftpc_params.svh]
/*
 Constants of the far-transfer privilege checker: descriptor field positions,
 gate type codes, fault codes and push widths.
 Assumes inclusion by bare name from the package; the modules only use its macros.
*/
// Function
// - Near jump, call and return forms skip all privilege checks.
// - The conforming flag of the target descriptor selects the check rules.
// - Direct nonconforming transfer faults unless current level equals descriptor level.
// - Direct nonconforming transfer needs request level no greater than current level.
// - Loaded nonconforming selector keeps the current level in its level field; through a gate to a lower-numbered level it takes the descriptor level.
// - Direct conforming transfer faults only if current level below descriptor level.
// - Conforming transfers ignore the selector request level completely; a gate transfer still checks it against the gate level.
// - Conforming transfer keeps current level and performs no stack switch.
// - Call gates come only from global or local tables, never interrupt table.
// - Gate gives target selector, entry offset and required privilege level.
// - A gate whose present flag is zero raises a not-present fault.
// - Parameter count means words for 16-bit, doublewords for 32-bit gates.
// - Gate size sets push width: 16-bit, 32-bit or 64-bit.
// - Wide gate: legacy low bytes, no count, upper offset must be canonical.
// - Wide gate upper type field must be zero; upper half as legacy faults.
// - Target through wide gate needs long bit set, default-size bit clear.
// - Extended mode decodes type 0CH as wide gate; no 32-bit gate exists.
// - Extended mode far call through 16-bit gate type 04H faults.
// - Wide gate pushes eight bytes, full pointer, no parameter copying.
// - Gate use needs current and request levels no greater than gate level.
`ifndef FTPC_PARAMS_SVH
`define FTPC_PARAMS_SVH
`define FTPC_GATE16_TYPE 4'h4
`define FTPC_GATE32_TYPE 4'hC
`define FTPC_OUT_PASS 2'h0
`define FTPC_OUT_PROT 2'h1
`define FTPC_OUT_NOTP 2'h2
`define FTPC_PUSH_2B 4'h2
`define FTPC_PUSH_4B 4'h4
`define FTPC_PUSH_8B 4'h8
`define FTPC_SEL_REQ_LSB 0
`define FTPC_SEL_TI_BIT 2
`define FTPC_G_OFFLO_LSB 0
`define FTPC_G_SEL_LSB 16
`define FTPC_G_CNT_LSB 32
`define FTPC_G_TYPE_LSB 40
`define FTPC_G_S_BIT 44
`define FTPC_G_LEVEL_LSB 45
`define FTPC_G_P_BIT 47
`define FTPC_G_OFFHI_LSB 48
`define FTPC_G_OFFUP_LSB 64
`define FTPC_G_UPTYPE_LSB 104
`define FTPC_CANON_MSB 47
`endif

// [rtl/ftpc_pkg.sv]
/*
 Types shared by the checker and its decode helper.
 Assumes the params header is on the include path.
*/
package ftpc_pkg;
    `include "ftpc_params.svh"
    typedef enum logic [1:0] {ftpc_tbl_global, ftpc_tbl_local, ftpc_tbl_intr} ftpc_tbl_type;
    typedef enum logic [1:0] {ftpc_xfer_jump, ftpc_xfer_call, ftpc_xfer_return} ftpc_xfer_type;
    typedef enum logic [1:0] {ftpc_g_none, ftpc_g_16, ftpc_g_32, ftpc_g_64} ftpc_gate_kind_type;
endpackage

// [sim/ftpc_checker_assertions.sv]
/*
 Port-level assertions for the far-transfer checker.
 Assumes one clock domain and the answer one cycle after each request.
*/
module ftpc_checker_assertions
    import ftpc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_req,
    input wire logic i_far,
    input wire logic i_via_gate,
    input wire ftpc_pkg::ftpc_tbl_type i_gate_tbl,
    input wire logic [127:0] i_gate_desc,
    input wire logic i_ext_mode,
    input wire logic [1:0] i_current_priv_level,
    input wire logic [15:0] i_sel,
    input wire logic i_cs_conforming,
    input wire logic [1:0] i_cs_descriptor_priv_level,
    input wire logic i_upper_half_access,
    input wire logic o_done,
    input wire logic [1:0] o_outcome,
    input wire logic [15:0] o_fault_sel,
    input wire logic [15:0] o_cs_sel,
    input wire logic [1:0] o_new_priv_level,
    input wire logic o_stack_switch
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);
    // Direct far request, and a gate request that passes the table, upper-half and system-flag screens
    wire logic dir = i_req && i_far && !i_via_gate;
    wire logic gate = i_req && i_far && i_via_gate && i_gate_tbl != ftpc_tbl_intr && !i_upper_half_access
        && !i_gate_desc[44];
    a_done_after_req: assert property (i_req |=> o_done) else $error("no done after request");
    a_idle_holds: assert property (!i_req |=> !o_done && $stable(o_outcome) && $stable(o_fault_sel))
        else $error("answer moved without request");
    a_near_passes: assert property (i_req && !i_far |=> o_outcome == 2'h0 && o_fault_sel == 16'h0)
        else $error("near form not passed");
    a_nonconf_level: assert property (dir && !i_cs_conforming
        && i_current_priv_level != i_cs_descriptor_priv_level |=> o_outcome == 2'h1 && o_fault_sel == $past(i_sel))
        else $error("level mismatch not faulted");
    a_nonconf_request: assert property (dir && !i_cs_conforming && i_sel[1:0] > i_current_priv_level
        |=> o_outcome == 2'h1) else $error("weak request level not faulted");
    a_conf_compare: assert property (dir && i_cs_conforming
        |=> (o_outcome == 2'h1) == ($past(i_current_priv_level) < $past(i_cs_descriptor_priv_level)))
        else $error("conforming check");
    a_level_kept: assert property (dir |=> o_outcome != 2'h0 || (o_cs_sel[1:0] == $past(i_current_priv_level)
        && o_new_priv_level == $past(i_current_priv_level))) else $error("level not kept");
    a_conf_no_switch: assert property (dir && i_cs_conforming |=> !o_stack_switch)
        else $error("stack switch on conforming");
    a_gate_intr: assert property (i_req && i_far && i_via_gate && i_gate_tbl == ftpc_tbl_intr
        |=> o_outcome == 2'h1) else $error("interrupt table gate accepted");
    a_gate_absent: assert property (gate && !i_gate_desc[47] && (i_gate_desc[43:40] == 4'hC
        || (i_gate_desc[43:40] == 4'h4 && !i_ext_mode)) |=> o_outcome == 2'h2) else $error("absent gate");
    a_ext_no_16: assert property (gate && i_ext_mode && i_gate_desc[43:40] == 4'h4 |=> o_outcome == 2'h1)
        else $error("narrow gate in extended mode");
    c_near: cover property (i_req && !i_far ##1 o_done);
    c_conf_pass: cover property (dir && i_cs_conforming ##1 o_outcome == 2'h0);
    c_absent: cover property (gate ##1 o_outcome == 2'h2);
endmodule

bind ftpc_checker ftpc_checker_assertions u_assert (.i_clk, .i_arst_n, .i_req, .i_far, .i_via_gate, .i_gate_tbl,
    .i_gate_desc, .i_ext_mode, .i_current_priv_level, .i_sel, .i_cs_conforming, .i_cs_descriptor_priv_level,
    .i_upper_half_access, .o_done, .o_outcome, .o_fault_sel, .o_cs_sel, .o_new_priv_level, .o_stack_switch);

// [sim/ftpc_gate_table_model.sv]
/*
 Descriptor table model: packs a 16-byte call-gate image from its fields.
 Assumes the bench sets the fields at the falling edge, before a request.
*/
module ftpc_gate_table_model (
    input wire logic [3:0] i_type,
    input wire logic i_present,
    input wire logic [1:0] i_level,
    input wire logic [15:0] i_sel,
    input wire logic [63:0] i_off,
    input wire logic [4:0] i_cnt,
    input wire logic [4:0] i_uptype,
    output logic [127:0] o_desc
);
    timeunit 1ns;
    timeprecision 1ps;
    // Legacy low half, then upper offset and type word; reserved bits stay low as a real table keeps them
    assign o_desc = {19'h0, i_uptype, 8'h0, i_off[63:16], i_present, i_level, 1'b0, i_type, 3'h0, i_cnt,
        i_sel, i_off[15:0]};
endmodule

// [sim/testbench.sv]
/*
 Self-checking bench: random direct transfers, then hand-made gate cases.
 Assumes the table model and checker are compiled first.
*/
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ftpc_pkg::*;
    logic i_clk = 1'b0, i_arst_n = 1'b0, i_req = 1'b0, i_far = 1'b0, i_via_gate = 1'b0, i_ext_mode = 1'b0;
    logic i_cs_conforming = 1'b0, i_cs_long = 1'b0, i_cs_default_size = 1'b0, i_upper_half_access = 1'b0;
    logic [1:0] i_current_priv_level = 2'h0, i_cs_descriptor_priv_level = 2'h0;
    logic [15:0] i_sel = 16'h0;
    ftpc_xfer_type i_xfer = ftpc_xfer_jump;
    ftpc_tbl_type i_gate_tbl = ftpc_tbl_global;
    logic [127:0] i_gate_desc;
    logic o_done, o_stack_switch, o_copy_dwords;
    logic [1:0] o_outcome, o_new_priv_level;
    logic [15:0] o_fault_sel, o_cs_sel;
    logic [63:0] o_entry_offset;
    logic [3:0] o_push_bytes, g_type = 4'h0;
    logic [4:0] o_copy_count, g_cnt = 5'h0, g_up = 5'h0;
    logic g_p = 1'b0;
    logic [1:0] g_level = 2'h0;
    logic [15:0] g_sel = 16'h0;
    logic [63:0] g_off = 64'h0;
    logic [17:0] e;
    logic go;
    integer seed = 32'h7B28F16E;
    int err_count = 0, cmp_count = 0;

    ftpc_checker DUT (.i_clk, .i_arst_n, .i_req, .i_far, .i_xfer, .i_via_gate, .i_gate_tbl, .i_gate_desc, .i_ext_mode,
        .i_current_priv_level, .i_sel, .i_cs_conforming, .i_cs_descriptor_priv_level,
        .i_cs_long, .i_cs_default_size,
        .i_upper_half_access, .o_done, .o_outcome, .o_fault_sel, .o_cs_sel, .o_entry_offset, .o_new_priv_level,
        .o_stack_switch, .o_push_bytes, .o_copy_count, .o_copy_dwords);
    ftpc_gate_table_model tables (.i_type(g_type), .i_present(g_p), .i_level(g_level), .i_sel(g_sel), .i_off(g_off),
        .i_cnt(g_cnt), .i_uptype(g_up), .o_desc(i_gate_desc));

    // Free-running core clock
    always #5 i_clk = ~i_clk;

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Request (or idle) at the falling edge; the answer stands one edge later
    task automatic step(input logic g, input logic [17:0] x);
        i_req = g;
        @(negedge i_clk);
        cmp(o_done, g, "done");
        if (g) cmp({o_outcome, o_fault_sel}, x, "outcome");
    endtask

    // Direct transfer: near always passes; conforming ignores the request level
    function automatic logic [17:0] exp_direct();
        if (i_far && (i_cs_conforming ? i_current_priv_level < i_cs_descriptor_priv_level
                : (i_current_priv_level != i_cs_descriptor_priv_level || i_sel[1:0] > i_current_priv_level)))
            return {2'h1, i_sel};
        return 18'h0;
    endfunction

    // A passing wide-gate call from level 3 to a level 0 target
    task automatic gdef();
        i_far = 1'b1;
        i_via_gate = 1'b1;
        i_xfer = ftpc_xfer_call;
        i_gate_tbl = ftpc_tbl_global;
        i_ext_mode = 1'b1;
        i_upper_half_access = 1'b0;
        i_current_priv_level = 2'h3;
        i_sel = 16'h0033;
        i_cs_conforming = 1'b0;
        i_cs_descriptor_priv_level = 2'h0;
        i_cs_long = 1'b1;
        i_cs_default_size = 1'b0;
        {g_type, g_p, g_level, g_sel, g_cnt, g_up} = {4'hC, 1'b1, 2'h3, 16'h0028, 5'h05, 5'h00};
        g_off = 64'hFFFF_8000_1234_5678;
    endtask

    // Watchdog: the tests need about 420 cycles
    initial begin
        #200000;
        err_count++;
        end_of_test();
    end

    initial begin
        repeat (8) @(negedge i_clk);
        i_arst_n = 1'b1;
        for (int n = 0; n < 400; n++) begin
            i_far = $random(seed);
            i_xfer = ftpc_xfer_type'(2'($unsigned($random(seed)) % 3));
            {i_current_priv_level, i_cs_descriptor_priv_level, i_cs_conforming, i_sel} = 21'($random(seed));
            go = $random(seed) % 4 != 0;
            e = exp_direct();
            step(go, e);
            if (go && i_far && e[17:16] == 2'h0) begin
                cmp(o_cs_sel, {i_sel[15:2], i_current_priv_level}, "cs level");
                cmp({o_new_priv_level, o_stack_switch}, {i_current_priv_level, 1'b0}, "level");
            end
        end
        $display("test direct done");
        // Mid-run reset: every output clears at once, with no clock edge needed
        i_req = 1'b0;
        i_arst_n = 1'b0;
        #1;
        cmp({o_done, o_outcome, o_fault_sel, o_cs_sel, o_new_priv_level, o_stack_switch}, 64'h0, "reset");
        cmp(o_entry_offset, 64'h0, "reset offset");
        cmp({o_push_bytes, o_copy_count, o_copy_dwords}, 64'h0, "reset push");
        @(negedge i_clk);
        i_arst_n = 1'b1;
        gdef();
        step(1'b1, 18'h0);
        cmp(o_entry_offset, g_off, "offset");
        cmp({o_cs_sel[1:0], o_new_priv_level, o_stack_switch}, {2'h0, 2'h0, 1'b1}, "switch");
        cmp(o_cs_sel[15:2], g_sel[15:2], "target");
        cmp({o_push_bytes, o_copy_count}, {4'h8, 5'h00}, "wide push");
        for (int k = 0; k < 2; k++) begin
            gdef();
            i_ext_mode = 1'b0;
            g_type = k ? 4'h4 : 4'hC;
            step(1'b1, 18'h0);
            cmp({o_push_bytes, o_copy_count, o_copy_dwords}, {k ? 4'h2 : 4'h4, 5'h05, !k}, "push");
        end
        for (int k = 0; k < 12; k++) begin
            gdef();
            e = {2'h1, 16'h0033};
            case (k)
                0: {g_p, e[17:16]} = {1'b0, 2'h2};
                1: i_gate_tbl = ftpc_tbl_intr;
                2: g_type = 4'h4;
                3: g_up = 5'h01;
                4: i_upper_half_access = 1'b1;
                5: g_off = 64'h0000_8000_0000_0000;
                6: g_level = 2'h2;
                7: {g_level, i_current_priv_level} = 4'hA;
                8: {i_cs_long, e[15:0]} = {1'b0, g_sel};
                9: {i_cs_default_size, e[15:0]} = {1'b1, g_sel};
                10: begin
                    i_xfer = ftpc_xfer_jump;
                    e[15:0] = g_sel;
                end
                default: begin
                    // Conforming target from a local-table gate: level kept, no switch
                    i_cs_conforming = 1'b1;
                    i_gate_tbl = ftpc_tbl_local;
                    e = 18'h0;
                end
            endcase
            step(1'b1, e);
            if (k == 11) cmp({o_cs_sel, o_new_priv_level, o_stack_switch}, {16'h002B, 2'h3, 1'b0}, "conf gate");
        end
        $display("test gate done");
        end_of_test();
    end
endmodule
